// *** hw/dtc_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - each timer sets its own overflow flag when it overflows, except timer 1 while timer 0 is split
// - overflow flag clears on vectoring; software may also set or clear it
// - software run bit per timer turns it on or off
// - external interrupt flag sets on configured edge or level at its pin
// - edge mode flag clears on vectoring; level mode flag follows the pin
// - software type bit per input selects falling edge or low level
// - gate set: timer advances only with pin high and run bit set
// - gate clear: timer advances whenever run bit set, pin ignored
// - counter-select clear: timer counts internal clock ticks
// - counter-select set: timer counts falling edges of its count pin
// - mode 0: 8-bit counter behind a 5-bit prescaler
// - mode 1: one 16-bit counter, no prescaler
// - mode 2: 8-bit low byte reloads from high byte on overflow
// - mode 3: timer 0 splits in two; timer 1 stops
module dtc_top import dtc_pkg::*; #(
    parameter int TICK_DIV = DTC_TICK_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic ext_irq_pin_0,
    input wire logic ext_irq_pin_1,
    input wire logic count_pin_0,
    input wire logic count_pin_1,
    input wire logic timer0_vector_ack,
    input wire logic timer1_vector_ack,
    input wire logic ext_irq0_vector_ack,
    input wire logic ext_irq1_vector_ack,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag
);
    localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    logic [7:0] timer_mode_control;
    logic timer0_run_control;
    logic timer1_run_control;
    logic ext_irq0_trigger_type;
    logic ext_irq1_trigger_type;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [3:0] falls;
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [3:0] nib0;
    logic [3:0] nib1;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc0_hi;
    logic ovf0;
    logic ovf0_hi;
    logic ovf1;
    logic set_tf0;
    logic set_tf1;
    logic wr_ctrl;
    logic wr_mode;

    initial begin
        if (TICK_DIV < 1) begin
            $error("dtc_top: TICK_DIV must be at least 1");
        end
    end

    assign wr_ctrl = sfr_wr && (sfr_addr == DTC_ADDR_RUN_IRQ_CTRL);
    assign wr_mode = sfr_wr && (sfr_addr == DTC_ADDR_MODE_CTRL);

    // internal clock: one-cycle tick every TICK_DIV core clocks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // falling edges of count pins (bits 0,1) and interrupt pins (bits 2,3)
    dtc_fall_detect #(
        .W(4)
    ) u_falls (
        .clk(clk),
        .rstn(rstn),
        .level_in({ext_irq_pin_1, ext_irq_pin_0, count_pin_1, count_pin_0}),
        .fall(falls)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_mode_control <= DTC_MODE_RESET;
        end else if (wr_mode) begin
            timer_mode_control <= sfr_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer0_run_control <= DTC_RUN_IRQ_RESET[DTC_BIT_T0_RUN];
            timer1_run_control <= DTC_RUN_IRQ_RESET[DTC_BIT_T1_RUN];
            ext_irq0_trigger_type <= DTC_RUN_IRQ_RESET[DTC_BIT_X0_TYPE];
            ext_irq1_trigger_type <= DTC_RUN_IRQ_RESET[DTC_BIT_X1_TYPE];
        end else if (wr_ctrl) begin
            timer0_run_control <= sfr_wdata[DTC_BIT_T0_RUN];
            timer1_run_control <= sfr_wdata[DTC_BIT_T1_RUN];
            ext_irq0_trigger_type <= sfr_wdata[DTC_BIT_X0_TYPE];
            ext_irq1_trigger_type <= sfr_wdata[DTC_BIT_X1_TYPE];
        end
    end

    assign nib0 = timer_mode_control[DTC_MODE_T0_LSB +: 4];
    assign nib1 = timer_mode_control[DTC_MODE_T1_LSB +: 4];
    assign mode0 = {nib0[DTC_NIB_MODE_HI], nib0[DTC_NIB_MODE_LO]};
    assign mode1 = {nib1[DTC_NIB_MODE_HI], nib1[DTC_NIB_MODE_LO]};

    // gate: pin high is needed only while the gate bit is set
    assign run0 = timer0_run_control
        && (!nib0[DTC_NIB_GATE] || ext_irq_pin_0);
    assign run1 = timer1_run_control
        && (!nib1[DTC_NIB_GATE] || ext_irq_pin_1);

    // counter-select picks the pin edge, otherwise the internal tick
    assign inc0 = run0 && (nib0[DTC_NIB_CSEL] ? falls[0] : tick);
    assign inc1 = run1 && (mode1 != DTC_MODE_SPLIT)
        && (nib1[DTC_NIB_CSEL] ? falls[1] : tick);
    // split high half is a plain timer run by timer 1's run bit only
    assign inc0_hi = timer1_run_control && tick;

    dtc_counter #(
        .SPLIT_OK(1'b1)
    ) u_timer0 (
        .clk(clk),
        .rstn(rstn),
        .mode(mode0),
        .inc(inc0),
        .inc_hi(inc0_hi),
        .wr_lo(sfr_wr && sfr_addr == DTC_ADDR_T0_LOW),
        .wr_hi(sfr_wr && sfr_addr == DTC_ADDR_T0_HIGH),
        .wdata(sfr_wdata),
        .lo(timer0_low_byte),
        .hi(timer0_high_byte),
        .ovf(ovf0),
        .ovf_hi(ovf0_hi)
    );

    dtc_counter #(
        .SPLIT_OK(1'b0)
    ) u_timer1 (
        .clk(clk),
        .rstn(rstn),
        .mode(mode1),
        .inc(inc1),
        .inc_hi(1'b0),
        .wr_lo(sfr_wr && sfr_addr == DTC_ADDR_T1_LOW),
        .wr_hi(sfr_wr && sfr_addr == DTC_ADDR_T1_HIGH),
        .wdata(sfr_wdata),
        .lo(timer1_low_byte),
        .hi(timer1_high_byte),
        .ovf(ovf1),
        .ovf_hi()
    );

    // while timer 0 is split, its high half owns timer 1's flag
    assign set_tf0 = ovf0;
    assign set_tf1 = (mode0 == DTC_MODE_SPLIT) ? ovf0_hi : ovf1;

    // hardware set wins over vector clear and software write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer0_overflow_flag <= DTC_RUN_IRQ_RESET[DTC_BIT_T0_OVF];
            timer1_overflow_flag <= DTC_RUN_IRQ_RESET[DTC_BIT_T1_OVF];
        end else begin
            if (set_tf0) begin
                timer0_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer0_overflow_flag <= sfr_wdata[DTC_BIT_T0_OVF];
            end else if (timer0_vector_ack) begin
                timer0_overflow_flag <= 1'b0;
            end
            if (set_tf1) begin
                timer1_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer1_overflow_flag <= sfr_wdata[DTC_BIT_T1_OVF];
            end else if (timer1_vector_ack) begin
                timer1_overflow_flag <= 1'b0;
            end
        end
    end

    // level mode: flag mirrors the active-low pin, so software writes have no effect
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_irq0_flag <= DTC_RUN_IRQ_RESET[DTC_BIT_X0_FLAG];
        end else if (!ext_irq0_trigger_type) begin
            ext_irq0_flag <= ~ext_irq_pin_0;
        end else if (falls[2]) begin
            ext_irq0_flag <= 1'b1;
        end else if (wr_ctrl) begin
            ext_irq0_flag <= sfr_wdata[DTC_BIT_X0_FLAG];
        end else if (ext_irq0_vector_ack) begin
            ext_irq0_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_irq1_flag <= DTC_RUN_IRQ_RESET[DTC_BIT_X1_FLAG];
        end else if (!ext_irq1_trigger_type) begin
            ext_irq1_flag <= ~ext_irq_pin_1;
        end else if (falls[3]) begin
            ext_irq1_flag <= 1'b1;
        end else if (wr_ctrl) begin
            ext_irq1_flag <= sfr_wdata[DTC_BIT_X1_FLAG];
        end else if (ext_irq1_vector_ack) begin
            ext_irq1_flag <= 1'b0;
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                DTC_ADDR_RUN_IRQ_CTRL: begin
                    sfr_rdata <= {timer1_overflow_flag, timer1_run_control,
                        timer0_overflow_flag, timer0_run_control,
                        ext_irq1_flag, ext_irq1_trigger_type,
                        ext_irq0_flag, ext_irq0_trigger_type};
                end
                DTC_ADDR_MODE_CTRL: sfr_rdata <= timer_mode_control;
                DTC_ADDR_T0_LOW: sfr_rdata <= timer0_low_byte;
                DTC_ADDR_T1_LOW: sfr_rdata <= timer1_low_byte;
                DTC_ADDR_T0_HIGH: sfr_rdata <= timer0_high_byte;
                DTC_ADDR_T1_HIGH: sfr_rdata <= timer1_high_byte;
                default: sfr_rdata <= DTC_UNMAPPED_READ;
            endcase
        end
    end
endmodule

// *** include/dtc_pkg.sv ***
package dtc_pkg;
    // special function register addresses
    localparam logic [7:0] DTC_ADDR_RUN_IRQ_CTRL = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE_CTRL = 8'h89;
    localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
    localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
    localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8c;
    localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8d;
    // unimplemented locations read high
    localparam logic [7:0] DTC_UNMAPPED_READ = 8'hff;

    // run and interrupt control field positions
    localparam int DTC_BIT_T1_OVF = 7;
    localparam int DTC_BIT_T1_RUN = 6;
    localparam int DTC_BIT_T0_OVF = 5;
    localparam int DTC_BIT_T0_RUN = 4;
    localparam int DTC_BIT_X1_FLAG = 3;
    localparam int DTC_BIT_X1_TYPE = 2;
    localparam int DTC_BIT_X0_FLAG = 1;
    localparam int DTC_BIT_X0_TYPE = 0;

    // mode control: one nibble per timer, timer 1 in the upper nibble
    localparam int DTC_MODE_T1_LSB = 4;
    localparam int DTC_MODE_T0_LSB = 0;
    localparam int DTC_NIB_GATE = 3;
    localparam int DTC_NIB_CSEL = 2;
    localparam int DTC_NIB_MODE_HI = 1;
    localparam int DTC_NIB_MODE_LO = 0;

    localparam logic [7:0] DTC_RUN_IRQ_RESET = 8'h00;
    localparam logic [7:0] DTC_MODE_RESET = 8'h00;
    localparam logic [7:0] DTC_COUNT_RESET = 8'h00;

    // mode 0 prescaler width in the low byte
    localparam int DTC_PRESCALE_BITS = 5;
    // core clocks per internal timer tick
    localparam int DTC_TICK_DIV = 12;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'b00,
        DTC_MODE_16BIT = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_e;
endpackage

// *** hw/dtc_fall_detect.sv ***
`timescale 1ns/1ps
module dtc_fall_detect import dtc_pkg::*; #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev;

    initial begin
        if (W < 1) begin
            $error("dtc_fall_detect: W must be at least 1");
        end
    end

    // prev resets high so a pin held low at reset gives a falling edge
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!rstn) begin
                prev[i] <= 1'b1;
                fall[i] <= 1'b0;
            end else begin
                prev[i] <= level_in[i];
                fall[i] <= prev[i] & ~level_in[i];
            end
        end
    end
endmodule

// *** hw/dtc_counter.sv ***
`timescale 1ns/1ps
module dtc_counter import dtc_pkg::*; #(
    parameter bit SPLIT_OK = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode,
    input wire logic inc,
    input wire logic inc_hi,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [7:0] lo,
    output logic [7:0] hi,
    output logic ovf,
    output logic ovf_hi
);
    localparam logic [DTC_PRESCALE_BITS-1:0] PRE_MAX = '1;
    logic [15:0] next_wide;
    logic pre_wrap;

    assign next_wide = {hi, lo} + 16'h0001;
    assign pre_wrap = (lo[DTC_PRESCALE_BITS-1:0] == PRE_MAX);

    // software writes win over a same-cycle increment
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lo <= DTC_COUNT_RESET;
            ovf <= 1'b0;
        end else begin
            ovf <= 1'b0;
            if (wr_lo) begin
                lo <= wdata;
            end else if (inc) begin
                case (mode)
                    DTC_MODE_13BIT: begin
                        // upper three low-byte bits are left alone
                        lo[DTC_PRESCALE_BITS-1:0] <= pre_wrap ? '0
                            : lo[DTC_PRESCALE_BITS-1:0] + 1'b1;
                        ovf <= pre_wrap && (hi == 8'hff);
                    end
                    DTC_MODE_16BIT: begin
                        lo <= next_wide[7:0];
                        ovf <= ({hi, lo} == 16'hffff);
                    end
                    DTC_MODE_RELOAD: begin
                        lo <= (lo == 8'hff) ? hi : lo + 8'h01;
                        ovf <= (lo == 8'hff);
                    end
                    default: begin
                        lo <= lo + 8'h01;
                        ovf <= (lo == 8'hff);
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hi <= DTC_COUNT_RESET;
            ovf_hi <= 1'b0;
        end else begin
            ovf_hi <= 1'b0;
            if (wr_hi) begin
                hi <= wdata;
            end else if (mode == DTC_MODE_SPLIT && SPLIT_OK) begin
                if (inc_hi) begin
                    hi <= hi + 8'h01;
                    ovf_hi <= (hi == 8'hff);
                end
            end else if (inc && mode == DTC_MODE_13BIT && pre_wrap) begin
                hi <= hi + 8'h01;
            end else if (inc && mode == DTC_MODE_16BIT) begin
                hi <= next_wide[15:8];
            end
        end
    end
endmodule

// *** test/dtc_checker.sv ***
`timescale 1ns/1ps
module dtc_checker import dtc_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic ext_irq_pin_0,
    input wire logic ext_irq_pin_1,
    input wire logic timer0_vector_ack,
    input wire logic timer1_vector_ack,
    input wire logic ext_irq0_flag,
    input wire logic ext_irq1_flag,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag
);
    logic [7:0] ctl_sh;
    logic [7:0] mode_sh;
    logic wr_ctl;
    logic sw_tf0;
    assign wr_ctl = sfr_wr && sfr_addr == DTC_ADDR_RUN_IRQ_CTRL;
    assign sw_tf0 = wr_ctl && sfr_wdata[5];
    // shadows of software-written controls, seen only through the bus ports
    always_ff @(posedge clk) begin
        if (!rstn) ctl_sh <= 8'h00;
        else if (wr_ctl) ctl_sh <= sfr_wdata;
    end
    always_ff @(posedge clk) begin
        if (!rstn) mode_sh <= 8'h00;
        else if (sfr_wr && sfr_addr == DTC_ADDR_MODE_CTRL) mode_sh <= sfr_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_X0_LEVEL: assert property ($past(rstn) && !ctl_sh[0] && !$past(ctl_sh[0])
        && !$past(wr_ctl) |-> ext_irq0_flag == !$past(ext_irq_pin_0))
        else $error("level flag 0 not following pin");
    AST_X1_LEVEL: assert property ($past(rstn) && !ctl_sh[2] && !$past(ctl_sh[2])
        && !$past(wr_ctl) |-> ext_irq1_flag == !$past(ext_irq_pin_1))
        else $error("level flag 1 not following pin");
    AST_X0_EDGE: assert property (ctl_sh[0] && $fell(ext_irq_pin_0)
        |-> ##[1:2] ext_irq0_flag) else $error("falling edge missed on input 0");
    AST_T0_ACK: assert property (timer0_vector_ack && !sfr_wr && !ctl_sh[4]
        && !$past(ctl_sh[4]) |=> !timer0_overflow_flag) else $error("tf0 not cleared by ack");
    AST_T1_ACK: assert property (timer1_vector_ack && !sfr_wr && !ctl_sh[6]
        && !$past(ctl_sh[6]) |=> !timer1_overflow_flag) else $error("tf1 not cleared by ack");
    AST_SW_SET: assert property (sw_tf0 |=> timer0_overflow_flag)
        else $error("tf0 not set by write");
    AST_T0_CAUSE: assert property ($rose(timer0_overflow_flag) |-> $past(sw_tf0)
        || $past(ctl_sh[4]) || $past(ctl_sh[4], 2)) else $error("tf0 rose without cause");
    AST_RD_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without read");
    AST_RD_UNMAP: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8d)
        |=> sfr_rdata == DTC_UNMAPPED_READ) else $error("unmapped read not high");
    AST_RD_MODE: assert property (sfr_rd && sfr_addr == DTC_ADDR_MODE_CTRL
        |=> sfr_rdata == $past(mode_sh)) else $error("mode readback wrong");
    cover property (timer0_overflow_flag && timer0_vector_ack);
    cover property ($rose(ext_irq1_flag));
    cover property ($rose(timer1_overflow_flag));
endmodule

bind dtc_top dtc_checker i_dtc_checker (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .ext_irq_pin_0, .ext_irq_pin_1, .timer0_vector_ack,
    .timer1_vector_ack, .ext_irq0_flag, .ext_irq1_flag, .timer0_overflow_flag,
    .timer1_overflow_flag);

// *** test/dtc_pin_model.sv ***
`timescale 1ns/1ps
module dtc_pin_model (
    input wire logic clk,
    output logic ext_irq_pin_0,
    output logic ext_irq_pin_1,
    output logic count_pin_0,
    output logic count_pin_1
);
    // pins idle high as if pulled up, so only a deliberate low makes an event
    initial begin
        {ext_irq_pin_0, ext_irq_pin_1, count_pin_0, count_pin_1} = 4'hf;
    end
    task automatic set_irq(input int i, input logic v);
        @(posedge clk);
        if (i == 1) ext_irq_pin_1 <= v;
        else ext_irq_pin_0 <= v;
    endtask
    // low for two edges so the synchronous sampler cannot miss it
    task automatic fall_cnt(input int i);
        @(posedge clk);
        if (i == 1) count_pin_1 <= 1'h0;
        else count_pin_0 <= 1'h0;
        repeat (2) @(posedge clk);
        count_pin_0 <= 1'h1;
        count_pin_1 <= 1'h1;
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import dtc_pkg::*;
    typedef struct {logic k; logic [7:0] a, lo, hi, elo, ehi; logic ef;} dtc_row_s;
    logic clk, rstn, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
    logic ext_irq_pin_0, ext_irq_pin_1, count_pin_0, count_pin_1;
    logic ext_irq0_flag, ext_irq1_flag, timer0_overflow_flag, timer1_overflow_flag;
    logic [3:0] ack_v;
    int err_total = 0;
    int n_tests = 0;
    dtc_row_s rows [14] = '{
        '{1'h0, 8'h89, 8'h5a, 8'h00, 8'h5a, 8'h00, 1'h0},
        '{1'h0, 8'h8a, 8'h3c, 8'h00, 8'h3c, 8'h00, 1'h0},
        '{1'h0, 8'h8b, 8'hc3, 8'h00, 8'hc3, 8'h00, 1'h0},
        '{1'h0, 8'h8c, 8'h96, 8'h00, 8'h96, 8'h00, 1'h0},
        '{1'h0, 8'h8d, 8'h69, 8'h00, 8'h69, 8'h00, 1'h0},
        '{1'h0, 8'h88, 8'h05, 8'h00, 8'h05, 8'h00, 1'h0},
        '{1'h0, 8'h87, 8'h12, 8'h00, 8'hff, 8'h00, 1'h0},
        '{1'h0, 8'h8e, 8'h34, 8'h00, 8'hff, 8'h00, 1'h0},
        '{1'h1, 8'h04, 8'hff, 8'hff, 8'he0, 8'h00, 1'h1},
        '{1'h1, 8'h04, 8'h1e, 8'h00, 8'h1f, 8'h00, 1'h0},
        '{1'h1, 8'h05, 8'hff, 8'h00, 8'h00, 8'h01, 1'h0},
        '{1'h1, 8'h05, 8'hff, 8'hff, 8'h00, 8'h00, 1'h1},
        '{1'h1, 8'h06, 8'hff, 8'hfe, 8'hfe, 8'hfe, 1'h1},
        '{1'h1, 8'h07, 8'hff, 8'h12, 8'h00, 8'h12, 1'h1}};

    dtc_top #(.TICK_DIV(2)) i_dtc_top (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .ext_irq_pin_0, .ext_irq_pin_1, .count_pin_0, .count_pin_1,
        .timer0_vector_ack(ack_v[0]), .timer1_vector_ack(ack_v[1]),
        .ext_irq0_vector_ack(ack_v[2]), .ext_irq1_vector_ack(ack_v[3]), .timer0_overflow_flag,
        .timer1_overflow_flag, .ext_irq0_flag, .ext_irq1_flag);
    dtc_pin_model i_dtc_pin_model (.clk, .ext_irq_pin_0, .ext_irq_pin_1, .count_pin_0,
        .count_pin_1);

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'h1;
        @(posedge clk);
        sfr_wr <= 1'h0;
        #1;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'h1;
        @(posedge clk);
        sfr_rd <= 1'h0;
        #1;
        rd_val = sfr_rdata;
        chk($sformatf("reg %h", a), exp, rd_val);
    endtask
    task automatic ack(int i);
        @(posedge clk);
        ack_v[i] <= 1'h1;
        @(posedge clk);
        ack_v[i] <= 1'h0;
        #1;
    endtask
    function automatic logic [7:0] xf(int i);
        return {7'h00, i == 1 ? ext_irq1_flag : ext_irq0_flag};
    endfunction
    task automatic cnt(int i);
        i_dtc_pin_model.fall_cnt(i);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic run_cnt(dtc_row_s r);
        wr(8'h88, 8'h00);
        wr(8'h89, r.a);
        wr(8'h8a, r.lo);
        wr(8'h8c, r.hi);
        wr(8'h88, 8'h10);
        cnt(0);
        chk("tf0", {7'h00, r.ef}, {7'h00, timer0_overflow_flag});
        wr(8'h88, 8'h20);
        chk("tf0 sw", 8'h01, {7'h00, timer0_overflow_flag});
        ack(0);
        chk("tf0 ack", 8'h00, {7'h00, timer0_overflow_flag});
        rd_chk(8'h8a, r.elo);
        rd_chk(8'h8c, r.ehi);
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    initial begin
        {rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, ack_v} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        for (int j = 0; j < 14; j++) begin
            if (rows[j].k) run_cnt(rows[j]);
            else begin
                wr(rows[j].a, rows[j].lo);
                rd_chk(rows[j].a, rows[j].elo);
            end
        end
        // gate, run and split behaviour of timer 1
        wr(8'h88, 8'h00);
        wr(8'h89, 8'hd0);
        wr(8'h8b, 8'hff);
        wr(8'h8d, 8'hff);
        i_dtc_pin_model.set_irq(1, 1'h0);
        wr(8'h88, 8'h40);
        cnt(1);
        rd_chk(8'h8b, 8'hff);
        i_dtc_pin_model.set_irq(1, 1'h1);
        cnt(1);
        chk("tf1", 8'h01, {7'h00, timer1_overflow_flag});
        rd_chk(8'h8b, 8'h00);
        wr(8'h88, 8'h80);
        ack(1);
        chk("tf1 ack", 8'h00, {7'h00, timer1_overflow_flag});
        wr(8'h89, 8'h50);
        i_dtc_pin_model.set_irq(1, 1'h0);
        wr(8'h88, 8'h40);
        cnt(1);
        rd_chk(8'h8b, 8'h01);
        wr(8'h88, 8'h00);
        cnt(1);
        rd_chk(8'h8b, 8'h01);
        wr(8'h89, 8'h70);
        wr(8'h88, 8'h40);
        cnt(1);
        rd_chk(8'h8b, 8'h01);
        i_dtc_pin_model.set_irq(1, 1'h1);
        // internal ticks every two clocks over about twenty-two clocks
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'h00);
        wr(8'h88, 8'h10);
        repeat (20) @(posedge clk);
        wr(8'h88, 8'h00);
        // an even window of 22 enabled edges holds exactly 11 ticks at TICK_DIV 2
        rd_chk(8'h8a, 8'h0b);
        n_tests++;
        if (rd_val < 8'h09 || rd_val > 8'h0c) begin
            $display("Error tick count expected 09..0c seen %h", rd_val);
            err_total++;
        end
        // split timer 0: high half ticks under timer 1's run bit and owns its flag
        wr(8'h89, 8'h03);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h40);
        repeat (4) @(posedge clk);
        #1 chk("split tf1", 8'h01, {7'h00, timer1_overflow_flag});
        wr(8'h88, 8'h00);
        rd_chk(8'h8c, 8'h02);
        for (int i = 0; i < 2; i++) begin
            wr(8'h88, 8'h05);
            i_dtc_pin_model.set_irq(i, 1'h0);
            repeat (4) @(posedge clk);
            #1 chk("edge flag", 8'h01, xf(i));
            i_dtc_pin_model.set_irq(i, 1'h1);
            repeat (2) @(posedge clk);
            #1 chk("edge held", 8'h01, xf(i));
            ack(2 + i);
            chk("edge ack", 8'h00, xf(i));
            wr(8'h88, 8'h00);
            i_dtc_pin_model.set_irq(i, 1'h0);
            repeat (2) @(posedge clk);
            #1 chk("level low", 8'h01, xf(i));
            i_dtc_pin_model.set_irq(i, 1'h1);
            repeat (2) @(posedge clk);
            #1 chk("level high", 8'h00, xf(i));
        end
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rd_chk(8'h88, 8'h00);
        rd_chk(8'h89, 8'h00);
        rd_chk(8'h8c, 8'h00);
        print_verdict();
    end
endmodule
